// [rtl/mle_core.v]
// Contract
// - Memory byte copied to working register, flags kept.
// - Immediate byte loaded into working register, flags kept.
// - Working register stored to memory, flags kept.
// - Idle instruction only advances program counter.
// - OR into working register, zero flag only.
// - OR written back to memory, zero flag only.
// - Subroutine exit pops counter, two cycles, flags kept.
// - Exit pops counter, loads immediate into working register.
// - Interrupt exit pops counter, sets global enable.
// - Left rotate, bit 7 into bit 0.
// - Left rotate through carry, only carry changes.
// - Right rotate, bit 0 into bit 7.
// - Right rotate through carry, only carry changes.
// - Borrow subtract updates signed, zero, aux, carry.
// - Decrement memory; zero result skips, two cycles.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "mle_regs.vh"

module mle_core #(
	parameter PC_W   = 12,
	parameter STK_AW = 3,
	parameter MEM_AW = 8
) (
	input  wire            core_clk,
	input  wire            rst,
	input  wire [7:0]      s_axi_awaddr,
	input  wire            s_axi_awvalid,
	output reg             s_axi_awready,
	input  wire [31:0]     s_axi_wdata,
	input  wire [3:0]      s_axi_wstrb,
	input  wire            s_axi_wvalid,
	output reg             s_axi_wready,
	output reg  [1:0]      s_axi_bresp,
	output reg             s_axi_bvalid,
	input  wire            s_axi_bready,
	input  wire [7:0]      s_axi_araddr,
	input  wire            s_axi_arvalid,
	output reg             s_axi_arready,
	output reg  [31:0]     s_axi_rdata,
	output reg  [1:0]      s_axi_rresp,
	output reg             s_axi_rvalid,
	input  wire            s_axi_rready,
	output reg             squash_prefetch,
	output reg             global_irq_enable
);
	// ----------------------------------------
	// State encoding
	// ----------------------------------------
	localparam [3:0] ST_IDLE  = 4'b0001;
	localparam [3:0] ST_FETCH = 4'b0010;
	localparam [3:0] ST_EXEC  = 4'b0100;
	localparam [3:0] ST_EXTRA = 4'b1000;

	reg [3:0]        state;
	reg [31:0]       instr;
	reg [7:0]        working_register;
	reg              carry_flag;
	reg              aux_carry_flag;
	reg              zero_flag;
	reg              signed_excess_flag;
	reg [PC_W-1:0]   pc;
	reg [PC_W-1:0]   stack [0:(1<<STK_AW)-1];
	reg [STK_AW-1:0] sp;
	reg [1:0]        last_cycles;
	reg [7:0]        wr_addr;
	reg [31:0]       wr_data;
	reg [3:0]        wr_strb;

	wire [4:0]        op       = instr[`MLE_F_OP];
	wire [7:0]        imm      = instr[`MLE_F_IMM];
	wire [7:0]        mem_rdata;
	wire              busy     = ~state[0];
	wire [STK_AW-1:0] sp_dec   = sp - {{(STK_AW-1){1'b0}}, 1'b1};
	wire              wr_go    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire              wr_instr = wr_go & (wr_addr == `MLE_OFS_INSTR);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer      i;
		begin
			merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = new_v[i*8 +: 8];
				end
			end
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `MLE_OFS_INSTR) || (a == `MLE_OFS_WREG) ||
				(a == `MLE_OFS_FLAGS) || (a == `MLE_OFS_PC) ||
				(a == `MLE_OFS_STATUS) || (a == `MLE_OFS_STACK);
		end
	endfunction

	// {signed excess, aux carry, carry, result}
	function [10:0] borrow_sub;
		input [7:0] a;
		input [7:0] b;
		input       cin;
		reg   [8:0] sum;
		reg   [4:0] lo;
		reg   [7:0] nb;
		begin
			nb  = ~b;
			sum = {1'b0, a} + {1'b0, nb} + {8'h00, cin};
			lo  = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + {4'h0, cin};
			borrow_sub = {(a[7] == nb[7]) && (sum[7] != a[7]), lo[4], sum[8], sum[7:0]};
		end
	endfunction

	// ----------------------------------------
	// Data memory and execution datapath
	// ----------------------------------------
	wire [31:0] pc_wr  = merge({{(32-PC_W){1'b0}}, pc}, wr_data, wr_strb);
	wire [31:0] stk_wr = merge({{(32-PC_W){1'b0}}, stack[sp]}, wr_data, wr_strb);
	reg  [7:0] res;
	reg        to_w;
	reg        to_m;
	reg        upd_z;
	reg        upd_c;
	reg        upd_sub;
	reg        new_c;
	reg        pop;
	reg        set_irq;
	reg        skip;
	reg [10:0] sub_out;

	mle_data_mem #(.AW(MEM_AW), .DW(8)) u_mem (
		.core_clk (core_clk),
		.we       (state[2] & to_m),
		.addr     (instr[`MLE_F_MADDR]),
		.wdata    (res),
		.rdata    (mem_rdata)
	);

	// Destination first, result second, so forms sharing a result share one item
	always @* begin
		res     = mem_rdata;
		to_w    = 1'b0;
		to_m    = 1'b0;
		upd_z   = 1'b0;
		upd_c   = 1'b0;
		upd_sub = 1'b0;
		new_c   = carry_flag;
		pop     = 1'b0;
		set_irq = 1'b0;
		skip    = 1'b0;
		sub_out = borrow_sub(working_register, mem_rdata, carry_flag);
		case (op)
		`MLE_OP_ROTL_MEM, `MLE_OP_ROTLC_MEM, `MLE_OP_ROTR_MEM, `MLE_OP_ROTRC_MEM,
		`MLE_OP_BSUB_MEM: to_m = 1'b1;
		`MLE_OP_ROTL_W, `MLE_OP_ROTLC_W, `MLE_OP_ROTR_W, `MLE_OP_ROTRC_W, `MLE_OP_BSUB_W,
		`MLE_OP_COPY_M2W: to_w = 1'b1;
		default:          to_w = 1'b0;
		endcase
		case (op)
		`MLE_OP_LOAD_IMM: begin
			res  = imm;
			to_w = 1'b1;
		end
		`MLE_OP_STORE: begin
			res  = working_register;
			to_m = 1'b1;
		end
		`MLE_OP_OR_MEM, `MLE_OP_OR_IMM, `MLE_OP_OR_INTO_MEM: begin
			res   = working_register | ((op == `MLE_OP_OR_IMM) ? imm : mem_rdata);
			to_m  = (op == `MLE_OP_OR_INTO_MEM);
			to_w  = ~to_m;
			upd_z = 1'b1;
		end
		`MLE_OP_SUB_EXIT:                   pop = 1'b1;
		`MLE_OP_SUB_EXIT_IMM: begin
			pop  = 1'b1;
			res  = imm;
			to_w = 1'b1;
		end
		`MLE_OP_IRQ_EXIT: begin
			pop     = 1'b1;
			set_irq = 1'b1;
		end
		`MLE_OP_ROTL_MEM, `MLE_OP_ROTL_W:   res = {mem_rdata[6:0], mem_rdata[7]};
		`MLE_OP_ROTLC_MEM, `MLE_OP_ROTLC_W: begin
			res   = {mem_rdata[6:0], carry_flag};
			new_c = mem_rdata[7];
			upd_c = 1'b1;
		end
		`MLE_OP_ROTR_MEM, `MLE_OP_ROTR_W:   res = {mem_rdata[0], mem_rdata[7:1]};
		`MLE_OP_ROTRC_MEM, `MLE_OP_ROTRC_W: begin
			res   = {carry_flag, mem_rdata[7:1]};
			new_c = mem_rdata[0];
			upd_c = 1'b1;
		end
		`MLE_OP_BSUB_W, `MLE_OP_BSUB_MEM: begin
			res     = sub_out[7:0];
			new_c   = sub_out[8];
			upd_sub = 1'b1;
		end
		`MLE_OP_DEC_SKIP: begin
			res  = mem_rdata - `MLE_ONE_BYTE;
			to_m = 1'b1;
			skip = (res == `MLE_RST_BYTE);
		end
		default:                            res = mem_rdata;
		endcase
	end

	// ----------------------------------------
	// Sequencer and register file
	// ----------------------------------------
	// Execution updates sit below software writes, so they win a same-cycle clash
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state              <= ST_IDLE;
			instr              <= `MLE_RST_WORD;
			working_register   <= `MLE_RST_BYTE;
			carry_flag         <= 1'b0;
			aux_carry_flag     <= 1'b0;
			zero_flag          <= 1'b0;
			signed_excess_flag <= 1'b0;
			global_irq_enable  <= 1'b0;
			pc                 <= {PC_W{1'b0}};
			sp                 <= {STK_AW{1'b0}};
			last_cycles        <= 2'h0;
			squash_prefetch    <= 1'b0;
		end else begin
			if (wr_go) begin
				case (wr_addr)
				`MLE_OFS_INSTR: begin
					if (!busy) begin
						instr <= merge(instr, wr_data, wr_strb);
						state <= ST_FETCH;
					end
				end
				`MLE_OFS_WREG:  if (wr_strb[0]) working_register <= wr_data[7:0];
				`MLE_OFS_FLAGS: if (wr_strb[0]) {global_irq_enable, signed_excess_flag, zero_flag,
					aux_carry_flag, carry_flag} <= wr_data[`MLE_B_IRQ_EN:`MLE_B_CARRY];
				`MLE_OFS_PC:    pc <= pc_wr[PC_W-1:0];
				`MLE_OFS_STACK: begin
					stack[sp] <= stk_wr[PC_W-1:0];
					sp        <= sp + {{(STK_AW-1){1'b0}}, 1'b1};
				end
				default:        sp <= sp;
				endcase
			end
			case (state)
			ST_IDLE:  squash_prefetch <= 1'b0;
			ST_FETCH: state <= ST_EXEC;
			ST_EXEC: begin
				if (to_w) working_register <= res;
				if (upd_z) zero_flag <= (res == `MLE_RST_BYTE);
				if (upd_c) carry_flag <= new_c;
				if (upd_sub) begin
					carry_flag         <= new_c;
					zero_flag          <= (res == `MLE_RST_BYTE);
					aux_carry_flag     <= sub_out[9];
					signed_excess_flag <= sub_out[10];
				end
				if (set_irq) global_irq_enable <= 1'b1;
				if (pop) begin
					pc <= stack[sp_dec];
					sp <= sp_dec;
				end else begin
					pc <= pc + (skip ? {{(PC_W-2){1'b0}}, 2'b10} : {{(PC_W-1){1'b0}}, 1'b1});
				end
				squash_prefetch <= skip;
				last_cycles     <= (pop || skip) ? `MLE_CYC_TWO : `MLE_CYC_ONE;
				state           <= (pop || skip) ? ST_EXTRA : ST_IDLE;
			end
			ST_EXTRA: begin
				squash_prefetch <= 1'b0;
				state           <= ST_IDLE;
			end
			default:  state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	// Address and data are each held until the response is taken
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `MLE_RESP_OKAY;
			wr_addr       <= `MLE_RST_BYTE;
			wr_data       <= `MLE_RST_WORD;
			wr_strb       <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr       <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (!mapped(wr_addr) || wr_addr == `MLE_OFS_STATUS ||
					(wr_instr && busy)) ? `MLE_RESP_SLVERR : `MLE_RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	reg [31:0] rd_mux;
	wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};

	always @* begin
		rd_mux = `MLE_RST_WORD;
		case (rd_addr)
		`MLE_OFS_INSTR:  rd_mux = instr;
		`MLE_OFS_WREG:   rd_mux[7:0] = working_register;
		`MLE_OFS_FLAGS:  rd_mux[`MLE_B_IRQ_EN:`MLE_B_CARRY] = {global_irq_enable,
			signed_excess_flag, zero_flag, aux_carry_flag, carry_flag};
		`MLE_OFS_PC:     rd_mux[PC_W-1:0] = pc;
		`MLE_OFS_STATUS: begin
			rd_mux[`MLE_B_BUSY]   = busy;
			rd_mux[`MLE_B_SQUASH] = squash_prefetch;
			rd_mux[`MLE_F_CYCLES] = last_cycles;
			rd_mux[`MLE_B_SP_LO +: STK_AW] = sp;
		end
		`MLE_OFS_STACK:  rd_mux[PC_W-1:0] = stack[sp_dec];
		default:         rd_mux = `MLE_RST_WORD;
		endcase
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `MLE_RST_WORD;
			s_axi_rresp   <= `MLE_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_mux;
				s_axi_rresp   <= mapped(rd_addr) ? `MLE_RESP_OKAY : `MLE_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // mle_core

// [rtl/mle_regs.vh]
`ifndef MLE_REGS_VH
`define MLE_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MLE_OFS_INSTR   8'h00
`define MLE_OFS_WREG    8'h04
`define MLE_OFS_FLAGS   8'h08
`define MLE_OFS_PC      8'h0C
`define MLE_OFS_STATUS  8'h10
`define MLE_OFS_STACK   8'h14

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define MLE_F_OP        4:0
`define MLE_F_MADDR     15:8
`define MLE_F_IMM       23:16

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define MLE_B_CARRY     0
`define MLE_B_AUX       1
`define MLE_B_ZERO      2
`define MLE_B_SIGNED    3
`define MLE_B_IRQ_EN    4

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define MLE_B_BUSY      0
`define MLE_B_SQUASH    1
`define MLE_F_CYCLES    3:2
`define MLE_B_SP_LO     8

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define MLE_OP_COPY_M2W     5'h00
`define MLE_OP_LOAD_IMM     5'h01
`define MLE_OP_STORE        5'h02
`define MLE_OP_IDLE         5'h03
`define MLE_OP_OR_MEM       5'h04
`define MLE_OP_OR_IMM       5'h05
`define MLE_OP_OR_INTO_MEM  5'h06
`define MLE_OP_SUB_EXIT     5'h07
`define MLE_OP_SUB_EXIT_IMM 5'h08
`define MLE_OP_IRQ_EXIT     5'h09
`define MLE_OP_ROTL_MEM     5'h0A
`define MLE_OP_ROTL_W       5'h0B
`define MLE_OP_ROTLC_MEM    5'h0C
`define MLE_OP_ROTLC_W      5'h0D
`define MLE_OP_ROTR_MEM     5'h0E
`define MLE_OP_ROTR_W       5'h0F
`define MLE_OP_ROTRC_MEM    5'h10
`define MLE_OP_ROTRC_W      5'h11
`define MLE_OP_BSUB_W       5'h12
`define MLE_OP_BSUB_MEM     5'h13
`define MLE_OP_DEC_SKIP     5'h14

// ----------------------------------------
// Reset values, counts and bus answers
// ----------------------------------------
`define MLE_RST_BYTE    8'h00
`define MLE_RST_WORD    32'h0000_0000
`define MLE_ONE_BYTE    8'h01
`define MLE_CYC_ONE     2'h1
`define MLE_CYC_TWO     2'h2
`define MLE_RESP_OKAY   2'h0
`define MLE_RESP_SLVERR 2'h2

`endif

// [rtl/mle_data_mem.v]
`timescale 1ns/1ps

// ----------------------------------------
// Data memory, registered read
// ----------------------------------------
module mle_data_mem #(
	parameter AW = 8,
	parameter DW = 8
) (
	input  wire          core_clk,
	input  wire          we,
	input  wire [AW-1:0] addr,
	input  wire [DW-1:0] wdata,
	output reg  [DW-1:0] rdata
);
	reg [DW-1:0] store [0:(1<<AW)-1];

	// No reset: contents are undefined until written
	always @(posedge core_clk) begin
		if (we) begin
			store[addr] <= wdata;
		end
		rdata <= store[addr];
	end
endmodule // mle_data_mem

// [sim/mle_core_props.sv]
`timescale 1ns/1ps
// --------------------------------
// Handshake and skip timing checks
// --------------------------------
module mle_core_props (
	input wire        core_clk,
	input wire        rst,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        squash_prefetch,
	input wire        global_irq_enable
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (rst);
	aw_taken_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address ready did not drop");
	b_after_a: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
		else $error("write answer while channels open");
	b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not released");
	ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready) else $error("read not released");
	squash_pulse_a: assert property ($rose(squash_prefetch) |=> !squash_prefetch)
		else $error("squash longer than one cycle");
	sq_c: cover property (squash_prefetch);
	err_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	irq_c: cover property ($rose(global_irq_enable));
endmodule // mle_core_props

bind mle_core mle_core_props i_props (
	.core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .squash_prefetch(squash_prefetch),
	.global_irq_enable(global_irq_enable)
);

// [sim/tb.sv]
`timescale 1ns/1ps
`include "mle_regs.vh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end

module tb;
	reg         core_clk = 1'b0;
	reg         rst      = 1'b1;
	reg  [7:0]  awaddr   = 8'h00;
	reg  [7:0]  araddr   = 8'h00;
	reg  [31:0] wdata    = 32'h0;
	reg  [3:0]  strb     = 4'hF;
	reg         awvalid  = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire        awready, wready, bvalid, arready, rvalid, squash, irq_en;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	reg  [31:0] d, pc0, st;
	reg  [1:0]  rsp;
	reg  [7:0]  e;
	integer     n_errors = 0, n_checks = 0, n_sq = 0, s0, i;

	always #25 core_clk = ~core_clk;
	// Pulse lasts one cycle, so count it rather than poll it
	always @(posedge core_clk) if (squash === 1'b1) n_sq <= n_sq + 1;

	mle_core i_dut (
		.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.squash_prefetch(squash), .global_irq_enable(irq_en)
	);

	// --------------------------------
	// Bus and instruction tasks
	// --------------------------------
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task tmo;
		n_errors++;
		$display("[ERR] handshake exp done got timeout");
		stop_test;
	endtask

	// Ready is looked at mid-cycle, where it holds what the next edge samples
	task wr(input [7:0] a, input [31:0] v);
		integer j;
		reg     p, q, b;
		begin
			@(posedge core_clk);
			awaddr <= a;
			wdata <= v;
			{awvalid, wvalid, bready} <= 3'b111;
			{p, q, b} = 3'b111;
			for (j = 0; j < 40 && b; j++) begin
				@(negedge core_clk);
				{p, q, b} = {p && !awready, q && !wready, !bvalid};
				rsp = bresp;
				@(posedge core_clk);
				{awvalid, wvalid, bready} <= {p, q, b};
			end
			if (b)
				tmo;
		end
	endtask

	task rd(input [7:0] a, output [31:0] v);
		integer j;
		reg     p, r;
		begin
			@(posedge core_clk);
			araddr <= a;
			{arvalid, rready} <= 2'b11;
			{p, r} = 2'b11;
			for (j = 0; j < 40 && r; j++) begin
				@(negedge core_clk);
				{p, r} = {p && !arready, !rvalid};
				{rsp, v} = {rresp, rdata};
				@(posedge core_clk);
				{arvalid, rready} <= {p, r};
			end
			if (r)
				tmo;
		end
	endtask

	task ex(input [4:0] op, input [7:0] m, input [7:0] x);
		integer j;
		begin
			wr(`MLE_OFS_INSTR, {8'h00, x, m, 3'h0, op});
			st = 32'h1;
			for (j = 0; j < 20 && st[`MLE_B_BUSY]; j++)
				rd(`MLE_OFS_STATUS, st);
			if (st[`MLE_B_BUSY])
				tmo;
		end
	endtask

	task setm(input [7:0] a, input [7:0] v);
		ex(`MLE_OP_LOAD_IMM, 8'h00, v);
		ex(`MLE_OP_STORE, a, 8'h00);
	endtask

	task setwf(input [7:0] w, input [7:0] f);
		wr(`MLE_OFS_FLAGS, {24'h0, f});
		ex(`MLE_OP_LOAD_IMM, 8'h00, w);
	endtask

	task getm(input [7:0] a);
		ex(`MLE_OP_COPY_M2W, a, 8'h00);
		rd(`MLE_OFS_WREG, d);
	endtask

	task cwf(input [7:0] w, input [7:0] f);
		rd(`MLE_OFS_WREG, d);
		`CHK("wreg", w, d[7:0])
		rd(`MLE_OFS_FLAGS, d);
		`CHK("flags", f, d[7:0])
	endtask

	task cpc(input [31:0] v);
		rd(`MLE_OFS_PC, d);
		`CHK("pc", v, d)
	endtask

	task sb(input [4:0] op, input [7:0] m, input [7:0] w, input c, input [7:0] r, input [7:0] f);
		setm(8'h30, m);
		setwf(w, {7'h00, c});
		ex(op, 8'h30, 8'h00);
		cwf(op == `MLE_OP_BSUB_W ? r : w, f);
		getm(8'h30);
		`CHK("mem", op == `MLE_OP_BSUB_W ? m : r, d[7:0])
	endtask

	// --------------------------------
	// Test sequence
	// --------------------------------
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		rd(`MLE_OFS_STATUS, d);
		`CHK("status", 32'h0, d)
		`CHK("irq_en", 1'b0, irq_en)
		cwf(8'h00, 8'h00);
		rd(8'h1C, d);
		`CHK("rd_unmapped", {`MLE_RESP_SLVERR, 32'h0}, {rsp, d})
		wr(`MLE_OFS_STATUS, 32'h0);
		`CHK("wr_status", `MLE_RESP_SLVERR, rsp)
		// Lane 0 not strobed, so the working register must keep its value
		strb <= 4'hE;
		wr(`MLE_OFS_WREG, 32'hFF);
		strb <= 4'hF;
		`CHK("wr_lane", `MLE_RESP_OKAY, rsp)
		cwf(8'h00, 8'h00);
		$display("test reset done");
		setwf(8'h5A, 8'h0F);
		cwf(8'h5A, 8'h0F);
		ex(`MLE_OP_STORE, 8'h10, 8'h00);
		ex(`MLE_OP_LOAD_IMM, 8'h00, 8'h00);
		ex(`MLE_OP_COPY_M2W, 8'h10, 8'h00);
		cwf(8'h5A, 8'h0F);
		rd(`MLE_OFS_PC, pc0);
		ex(`MLE_OP_IDLE, 8'h10, 8'hFF);
		cpc(pc0 + 1);
		cwf(8'h5A, 8'h0F);
		$display("test moves done");
		setm(8'h11, 8'h24);
		setwf(8'h42, 8'h0F);
		ex(`MLE_OP_OR_MEM, 8'h11, 8'h00);
		cwf(8'h66, 8'h0B);
		ex(`MLE_OP_OR_IMM, 8'h00, 8'h81);
		cwf(8'hE7, 8'h0B);
		setwf(8'h00, 8'h03);
		ex(`MLE_OP_OR_IMM, 8'h00, 8'h00);
		cwf(8'h00, 8'h07);
		setwf(8'h18, 8'h0F);
		ex(`MLE_OP_OR_INTO_MEM, 8'h11, 8'h00);
		cwf(8'h18, 8'h0B);
		getm(8'h11);
		`CHK("mem", 8'h3C, d[7:0])
		$display("test or done");
		wr(`MLE_OFS_STACK, 32'h123);
		wr(`MLE_OFS_STACK, 32'h2A5);
		wr(`MLE_OFS_STACK, 32'h377);
		wr(`MLE_OFS_FLAGS, 32'h0F);
		ex(`MLE_OP_SUB_EXIT, 8'h00, 8'h00);
		`CHK("cycles", `MLE_CYC_TWO, st[`MLE_F_CYCLES])
		cpc(32'h377);
		cwf(8'h3C, 8'h0F);
		ex(`MLE_OP_SUB_EXIT_IMM, 8'h00, 8'hC3);
		cpc(32'h2A5);
		cwf(8'hC3, 8'h0F);
		wr(`MLE_OFS_FLAGS, 32'h0);
		ex(`MLE_OP_IRQ_EXIT, 8'h00, 8'h00);
		cpc(32'h123);
		`CHK("irq_en", 1'b1, irq_en)
		cwf(8'hC3, 8'h10);
		$display("test returns done");
		// Both carry values, so carry-in and carry-out are each seen to move
		for (i = 0; i < 16; i++) begin
			setm(8'h20, 8'h81);
			setwf(8'h00, 8'h0E | {7'h00, i[3]});
			ex(`MLE_OP_ROTL_MEM + {2'h0, i[2:0]}, 8'h20, 8'h00);
			e = i[2] ? (i[1] ? {i[3], 7'h40} : 8'hC0) : (i[1] ? {7'h01, i[3]} : 8'h03);
			cwf(i[0] ? e : 8'h00, i[1] ? 8'h0F : {7'h07, i[3]});
			getm(8'h20);
			`CHK("mem", i[0] ? 8'h81 : e, d[7:0])
		end
		$display("test rotates done");
		sb(`MLE_OP_BSUB_W, 8'h30, 8'h50, 1'b1, 8'h20, 8'h03);
		sb(`MLE_OP_BSUB_W, 8'h30, 8'h50, 1'b0, 8'h1F, 8'h01);
		sb(`MLE_OP_BSUB_W, 8'h30, 8'h30, 1'b1, 8'h00, 8'h07);
		sb(`MLE_OP_BSUB_MEM, 8'h01, 8'h80, 1'b1, 8'h7F, 8'h09);
		$display("test subtract done");
		setm(8'h40, 8'h02);
		wr(`MLE_OFS_FLAGS, 32'h0F);
		for (i = 0; i < 2; i++) begin
			rd(`MLE_OFS_PC, pc0);
			s0 = n_sq;
			ex(`MLE_OP_DEC_SKIP, 8'h40, 8'h00);
			cpc(pc0 + 1 + i);
			`CHK("cycles", `MLE_CYC_ONE + i[1:0], st[`MLE_F_CYCLES])
			`CHK("squash", i, n_sq - s0)
		end
		cwf(8'h02, 8'h0F);
		getm(8'h40);
		`CHK("mem", 8'h00, d[7:0])
		$display("test skip done");
		stop_test;
	end
endmodule // tb
